// File: sspc_pkg.sv
/*
 * Shared constants of the synchronous pin-controlled static memory.
 * Assumes nothing of its surroundings; imported by both design modules.
 */
package sspc_pkg;
    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    // shallow by default: the array is flip-flops, so a full-size part would not elaborate sensibly
    localparam int DEF_ADDR_W = 4;
    localparam int DEF_LANES = 4;
    localparam int DEF_LANE_W = 9;
    localparam int LSB_W = 2;
    localparam int BURST_W = 2;
    localparam int MAX_LANES = 4;
    // ------------------------------------------------------------
    // lane positions inside the packed enable vector
    // ------------------------------------------------------------
    localparam int LANE_A = 0;
    localparam int LANE_B = 1;
    localparam int LANE_C = 2;
    localparam int LANE_D = 3;
    // ------------------------------------------------------------
    // reset values and the burst step
    // ------------------------------------------------------------
    localparam logic [BURST_W-1:0] RST_CNT = 2'h0;
    localparam logic [1:0] RST_SNOOZE_SYNC = 2'h0;
    // output enable synchronizer starts at "disabled" so the bus stays quiet
    localparam logic [1:0] RST_OE_SYNC = 2'h3;
    localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
endpackage

// File: sspc_burst_seq.sv
/*
 * Burst address sequencer: turns the loaded low address bits and the
 * burst step into the low address bits of the current access.
 * Assumes the caller keeps the step counter and the order select.
 */
`timescale 1ns/10ps
`default_nettype none
module sspc_burst_seq #(
    parameter int CNT_W = sspc_pkg::BURST_W
) (
    input wire logic [CNT_W-1:0] base_lsb,
    input wire logic [CNT_W-1:0] step,
    input wire logic interleave,
    output logic [CNT_W-1:0] seq_lsb
);
    import sspc_pkg::*;

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    logic [CNT_W-1:0] lin_lsb;

    initial begin
        if (CNT_W < 1) begin
            $error("burst counter width must be at least one");
        end
    end

    // linear wraps within the burst, interleaved flips bits of the base
    assign lin_lsb = CNT_W'(base_lsb + step);
    assign seq_lsb = interleave ? (base_lsb ^ step) : lin_lsb; // RULE_19
endmodule
`default_nettype wire

// File: sspc_sram_pin_ctrl.sv
/*
 * Device-side control logic of a pipelined synchronous static memory with
 * no turnaround cycles: registered address, lane write enables, three chip
 * selects, clock enable, read/write select, burst, snooze and output enable.
 * Assumes a controller on ref_clk drives the synchronous pins; snooze and
 * output enable are asynchronous and are synchronized here.
 */
// Function
// RULE_01 - every address input is registered on the rising clock edge.
// RULE_02 - each active-low lane write enable gates writing of its own lane.
// RULE_03 - controller drives lane enables low to write, high to read.
// RULE_04 - two lanes a,b or four a..d; each covers byte plus parity.
// RULE_05 - address, data, selects, lane enables, burst control registered together.
// RULE_06 - primary active-low select enables, sampled only when an address loads.
// RULE_07 - secondary active-low select enables, sampled only when an address loads.
// RULE_08 - tertiary active-high select enables, sampled only when an address loads.
// RULE_09 - active-low clock enable lets edges act; sampled at rising edge.
// RULE_10 - clock enable high: ignore edges, hold all state, stretch prior cycle.
// RULE_11 - snooze high enters standby keeping all array contents.
// RULE_12 - while snoozing every other input is disregarded.
// RULE_13 - read/write select decides cycle type only when loading an address.
// RULE_14 - a read never turns into a write, nor back, without new load.
// RULE_15 - write with all lane enables low updates the whole data word.
// RULE_16 - active-low output enable turns data drivers on; high means undriven.
// RULE_17 - advance/load high advances burst counter, ignoring read/write select.
// RULE_18 - advance/load low at rising edge loads a new external address.
// RULE_19 - order select low linear, high interleaved; held while operating.
// RULE_20 - any inactive select at load: no access, array unchanged.
`timescale 1ns/10ps
`default_nettype none
module sspc_sram_pin_ctrl #(
    parameter int ADDR_W = sspc_pkg::DEF_ADDR_W,
    parameter int LANES = sspc_pkg::DEF_LANES,
    parameter int LANE_W = sspc_pkg::DEF_LANE_W
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic addr_lsb0,
    input wire logic addr_lsb1,
    input wire logic lane_a_wr_en_n,
    input wire logic lane_b_wr_en_n,
    input wire logic lane_c_wr_en_n,
    input wire logic lane_d_wr_en_n,
    input wire logic chip_sel_first_n,
    input wire logic chip_sel_second_n,
    input wire logic chip_sel_third,
    input wire logic clk_en_n,
    input wire logic wr_sel_n,
    input wire logic advance_load_sel,
    input wire logic burst_order_sel,
    input wire logic snooze_req,
    input wire logic out_en_n,
    input wire logic [LANES*LANE_W-1:0] data_in,
    output logic [LANES*LANE_W-1:0] data_out,
    output logic data_oe
);
    import sspc_pkg::*;

    // ------------------------------------------------------------
    // geometry and checks
    // ------------------------------------------------------------
    localparam int AW = ADDR_W + LSB_W;
    localparam int DEPTH = 1 << AW;
    localparam int DW = LANES * LANE_W;

    initial begin
        if (LANES != 2 && LANES != MAX_LANES) begin
            $error("lane count must be 2 or 4");
        end
        if (LANE_W != 8 && LANE_W != 9) begin
            $error("lane width must be 8 or 9");
        end
        if (ADDR_W < 1 || ADDR_W > 16) begin
            $error("upper address width must be 1 to 16");
        end
        // the burst sequencer works on exactly the two loaded low address bits
        if (LSB_W != BURST_W) begin
            $error("burst width must match the low address width");
        end
    end

    typedef struct packed {
        logic [DEPTH-1:0][DW-1:0] mem;
        logic [DW-1:0] rd_data;
        logic rd_valid;
        logic active;
        logic is_wr;
        logic [AW-1:0] base;
        logic [BURST_W-1:0] cnt;
        logic [1:0] snooze_sync;
        logic [1:0] oe_sync;
    } sspc_state_t;

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic sspc_selected(input logic cs1_n, input logic cs2_n, input logic cs3);
        sspc_selected = !cs1_n && !cs2_n && cs3;
    endfunction

    sspc_state_t st_r;
    sspc_state_t st_nxt;
    logic snooze_s;
    logic oe_n_s;
    logic load;
    logic sel_now;
    logic [MAX_LANES-1:0] all_en_n;
    logic [LANES-1:0] lane_we_n;
    logic [AW-1:0] load_addr;
    logic [AW-1:0] cur_addr;
    logic [BURST_W-1:0] step;
    logic [BURST_W-1:0] seq_lsb;
    logic [DW-1:0] wr_word;
    logic do_access;
    logic do_write;

    assign snooze_s = st_r.snooze_sync[1];
    assign oe_n_s = st_r.oe_sync[1];
    assign load = !advance_load_sel; // RULE_18
    assign sel_now = sspc_selected(chip_sel_first_n, chip_sel_second_n, chip_sel_third);
    assign all_en_n = {lane_d_wr_en_n, lane_c_wr_en_n, lane_b_wr_en_n, lane_a_wr_en_n};
    assign lane_we_n = all_en_n[LANES-1:0]; // RULE_04
    assign load_addr = {addr_in, addr_lsb1, addr_lsb0};
    assign step = BURST_W'(st_r.cnt + BURST_STEP); // RULE_17

    sspc_burst_seq #(
        .CNT_W(BURST_W)
    ) u_burst (
        .base_lsb(st_r.base[BURST_W-1:0]),
        .step(step),
        .interleave(burst_order_sel),
        .seq_lsb(seq_lsb)
    );

    // ------------------------------------------------------------
    // access decision
    // ------------------------------------------------------------
    always_comb begin
        if (load) begin
            cur_addr = load_addr;
            // selects only matter on a load; during a burst they are don't-care
            do_access = sel_now; // RULE_06 RULE_07 RULE_08 RULE_20
            do_write = !wr_sel_n; // RULE_13
        end else begin
            cur_addr = {st_r.base[AW-1:BURST_W], seq_lsb};
            do_access = st_r.active;
            do_write = st_r.is_wr; // RULE_14 RULE_17
        end
    end

    always_comb begin
        wr_word = st_r.mem[cur_addr];
        for (int i = 0; i < LANES; i++) begin
            if (!lane_we_n[i]) begin
                wr_word[i*LANE_W +: LANE_W] = data_in[i*LANE_W +: LANE_W]; // RULE_02 RULE_15
            end
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.snooze_sync = {st_r.snooze_sync[0], snooze_req};
        st_nxt.oe_sync = {st_r.oe_sync[0], out_en_n};
        if (snooze_s) begin
            // standby: nothing moves, the array keeps its contents
            st_nxt.rd_valid = st_r.rd_valid; // RULE_11 RULE_12
        end else if (clk_en_n) begin
            // suspended edge: the previous cycle simply lasts longer
            st_nxt.rd_valid = st_r.rd_valid; // RULE_09 RULE_10
        end else begin
            if (load) begin
                st_nxt.base = load_addr; // RULE_01 RULE_05
                st_nxt.cnt = RST_CNT;
                st_nxt.active = sel_now;
                st_nxt.is_wr = !wr_sel_n;
            end else begin
                st_nxt.cnt = step;
            end
            st_nxt.rd_valid = 1'b0;
            if (do_access && do_write) begin
                st_nxt.mem[cur_addr] = wr_word;
            end else if (do_access) begin
                st_nxt.rd_data = st_r.mem[cur_addr];
                st_nxt.rd_valid = 1'b1;
            end
        end
        if (reset) begin
            st_nxt = '0;
            st_nxt.cnt = RST_CNT;
            st_nxt.snooze_sync = RST_SNOOZE_SYNC;
            st_nxt.oe_sync = RST_OE_SYNC;
        end
    end

    always_ff @(posedge ref_clk) begin
        st_r <= st_nxt;
    end

    // ------------------------------------------------------------
    // data pins
    // ------------------------------------------------------------
    assign data_out = st_r.rd_data;
    // drivers also drop in standby so a snoozing part never fights the bus
    assign data_oe = st_r.rd_valid && !oe_n_s && !snooze_s; // RULE_16

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic live;
    assign live = !snooze_s && !clk_en_n;

    a_deselect_no_write: assert property (@(posedge ref_clk) disable iff (reset) // RULE_20
        live && load && !sel_now |=> $stable(st_r.mem) && !st_r.rd_valid && !st_r.active)
        else $error("deselected load touched the array");

    a_suspend_holds: assert property (@(posedge ref_clk) disable iff (reset) // RULE_10
        !snooze_s && clk_en_n |=> $stable(st_r.mem) && $stable(st_r.rd_data) && $stable(st_r.cnt)
            && $stable(st_r.rd_valid) && $stable(st_r.base))
        else $error("state moved while clock enable was high");

    a_snooze_retains: assert property (@(posedge ref_clk) disable iff (reset) // RULE_11
        snooze_s |=> $stable(st_r.mem) && $stable(st_r.base) && $stable(st_r.cnt))
        else $error("state moved during snooze");

    // pin level two edges back, since both asynchronous pins pass a two-stage synchronizer
    a_snooze_quiet: assert property (@(posedge ref_clk) disable iff (reset) // RULE_12
        $past(snooze_req, 2) |-> !data_oe)
        else $error("data driven during snooze");

    a_oe_gates_bus: assert property (@(posedge ref_clk) disable iff (reset) // RULE_16
        data_oe |-> !$past(out_en_n, 2) && st_r.rd_valid)
        else $error("data driven without output enable");

    a_load_read_data: assert property (@(posedge ref_clk) disable iff (reset) // RULE_18
        live && load && sel_now && wr_sel_n |=> st_r.rd_valid && data_out == $past(st_r.mem[cur_addr]))
        else $error("selected read did not return the addressed word");

    a_burst_type_kept: assert property (@(posedge ref_clk) disable iff (reset) // RULE_14
        live && !load |=> $stable(st_r.is_wr) && $stable(st_r.active) && st_r.cnt == $past(step))
        else $error("burst changed its cycle type or failed to advance");

    a_lane_a_gated: assert property (@(posedge ref_clk) disable iff (reset) // RULE_02
        live && do_access && do_write && lane_a_wr_en_n
        |=> st_r.mem[$past(cur_addr)][LANE_W-1:0] == $past(st_r.mem[cur_addr][LANE_W-1:0]))
        else $error("disabled lane a was written");

    a_full_write: assert property (@(posedge ref_clk) disable iff (reset) // RULE_15
        live && do_access && do_write && lane_we_n == '0 |=> st_r.mem[$past(cur_addr)] == $past(data_in))
        else $error("full-width write lost data");

    a_addr_captured: assert property (@(posedge ref_clk) disable iff (reset) // RULE_01
        live && load |=> st_r.base == $past(load_addr) && st_r.cnt == RST_CNT)
        else $error("address not captured on load");

    a_selects_on_load: assert property (@(posedge ref_clk) disable iff (reset) // RULE_06 RULE_07 RULE_08
        live && load |=> st_r.active == $past(!chip_sel_first_n && !chip_sel_second_n && chip_sel_third))
        else $error("chip selects not taken on load");

    a_read_keeps_array: assert property (@(posedge ref_clk) disable iff (reset) // RULE_13
        live && do_access && !do_write |=> $stable(st_r.mem))
        else $error("read access changed the array");

    a_write_no_readout: assert property (@(posedge ref_clk) disable iff (reset) // RULE_13
        live && do_access && do_write |=> !st_r.rd_valid && !data_oe)
        else $error("write access drove read data");

    a_burst_read_data: assert property (@(posedge ref_clk) disable iff (reset) // RULE_17
        live && !load && st_r.active && !st_r.is_wr |=> st_r.rd_valid && data_out == $past(st_r.mem[cur_addr]))
        else $error("burst read did not return the advanced word");

    a_idle_burst_quiet: assert property (@(posedge ref_clk) disable iff (reset) // RULE_20
        live && !load && !st_r.active |=> $stable(st_r.mem) && !st_r.rd_valid)
        else $error("burst after a deselected load made an access");

    a_linear_order: assert property (@(posedge ref_clk) disable iff (reset) // RULE_19
        !load && !burst_order_sel |-> cur_addr[BURST_W-1:0] == BURST_W'(st_r.base[BURST_W-1:0] + step))
        else $error("linear burst address out of sequence");

    a_interleave_order: assert property (@(posedge ref_clk) disable iff (reset) // RULE_19
        !load && burst_order_sel |-> cur_addr[BURST_W-1:0] == (st_r.base[BURST_W-1:0] ^ step))
        else $error("interleaved burst address out of sequence");

    // a gating check and a write check per lane, the parity bit rides with its byte
    for (genvar g = 0; g < LANES; g++) begin : g_lane_chk
        a_lane_gated: assert property (@(posedge ref_clk) disable iff (reset) // RULE_02 RULE_04
            live && do_access && do_write && lane_we_n[g]
            |=> st_r.mem[$past(cur_addr)][g*LANE_W +: LANE_W] == $past(st_r.mem[cur_addr][g*LANE_W +: LANE_W]))
            else $error("disabled lane was written");

        a_lane_taken: assert property (@(posedge ref_clk) disable iff (reset) // RULE_02 RULE_04
            live && do_access && do_write && !lane_we_n[g]
            |=> st_r.mem[$past(cur_addr)][g*LANE_W +: LANE_W] == $past(data_in[g*LANE_W +: LANE_W]))
            else $error("enabled lane was not written");
    end

    c_read: cover property (@(posedge ref_clk) disable iff (reset) live && load && sel_now && wr_sel_n);
    c_write: cover property (@(posedge ref_clk) disable iff (reset) live && load && sel_now && !wr_sel_n);
    c_burst: cover property (@(posedge ref_clk) disable iff (reset) live && !load && st_r.active);
    c_snooze: cover property (@(posedge ref_clk) disable iff (reset) snooze_s ##1 !snooze_s);
    c_interleave: cover property (@(posedge ref_clk) disable iff (reset) live && !load && st_r.active && burst_order_sel);
endmodule
`default_nettype wire

// File: sspc_ctl_model.sv
/*
 * Controller-side pin driver for the synchronous static memory.
 * Assumes the bench calls drive once a cycle, just after ref_clk rises.
 */
`timescale 1ns/10ps
`default_nettype none
module sspc_ctl_model (
    output var logic [3:0] addr_in,
    output var logic addr_lsb0,
    output var logic addr_lsb1,
    output var logic lane_a_wr_en_n,
    output var logic lane_b_wr_en_n,
    output var logic lane_c_wr_en_n,
    output var logic lane_d_wr_en_n,
    output var logic chip_sel_first_n,
    output var logic chip_sel_second_n,
    output var logic chip_sel_third,
    output var logic clk_en_n,
    output var logic wr_sel_n,
    output var logic advance_load_sel,
    output var logic [35:0] data_in
);
    task automatic drive(input logic ce, input logic adv, input logic [5:0] a, input logic wr,
                         input logic [3:0] ln, input logic [2:0] sel, input logic [35:0] d);
        clk_en_n = !ce;
        advance_load_sel = adv;
        {addr_in, addr_lsb1, addr_lsb0} = a;
        wr_sel_n = !wr;
        {lane_d_wr_en_n, lane_c_wr_en_n, lane_b_wr_en_n, lane_a_wr_en_n} = ~ln;
        {chip_sel_third, chip_sel_second_n, chip_sel_first_n} = {sel[2], ~sel[1:0]};
        // with no lane enabled the data toggles, so a stale bus value never passes for data
        data_in = (ln != 4'h0) ? d : ~data_in;
    endtask
    initial begin
        data_in = 36'h0;
        drive(1'b0, 1'b0, 6'h0, 1'b0, 4'h0, 3'h0, 36'h0);
    end
endmodule
`default_nettype wire

// File: sync_sram_pin_control_bench.sv
/*
 * Self-checking bench of the static memory pin control.
 * Assumes sspc_ctl_model drives the synchronous pins except order select;
 * reset, snooze, output enable and order select are driven here.
 */
`timescale 1ns/10ps
`default_nettype none
module sync_sram_pin_control_bench;
    import sspc_pkg::*;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic snooze_req = 1'b0;
    logic out_en_n = 1'b0;
    logic burst_order_sel = 1'b0;
    logic [3:0] addr_in;
    logic addr_lsb0, addr_lsb1, clk_en_n, wr_sel_n, advance_load_sel, data_oe;
    logic lane_a_wr_en_n, lane_b_wr_en_n, lane_c_wr_en_n, lane_d_wr_en_n;
    logic chip_sel_first_n, chip_sel_second_n, chip_sel_third;
    logic [35:0] data_in, data_out;
    logic [35:0] mem_e [64];
    int err_total = 0;
    int num_checks = 0;
    always #20 ref_clk = ~ref_clk;
    sspc_sram_pin_ctrl #(.ADDR_W(4), .LANES(4), .LANE_W(9)) i_dut (.ref_clk(ref_clk), .reset(reset),
        .addr_in(addr_in), .addr_lsb0(addr_lsb0), .addr_lsb1(addr_lsb1), .lane_a_wr_en_n(lane_a_wr_en_n),
        .lane_b_wr_en_n(lane_b_wr_en_n), .lane_c_wr_en_n(lane_c_wr_en_n), .lane_d_wr_en_n(lane_d_wr_en_n),
        .chip_sel_first_n(chip_sel_first_n), .chip_sel_second_n(chip_sel_second_n),
        .chip_sel_third(chip_sel_third), .clk_en_n(clk_en_n), .wr_sel_n(wr_sel_n),
        .advance_load_sel(advance_load_sel), .burst_order_sel(burst_order_sel), .snooze_req(snooze_req),
        .out_en_n(out_en_n), .data_in(data_in), .data_out(data_out), .data_oe(data_oe));
    sspc_ctl_model i_ctl (.addr_in(addr_in), .addr_lsb0(addr_lsb0), .addr_lsb1(addr_lsb1),
        .lane_a_wr_en_n(lane_a_wr_en_n), .lane_b_wr_en_n(lane_b_wr_en_n), .lane_c_wr_en_n(lane_c_wr_en_n),
        .lane_d_wr_en_n(lane_d_wr_en_n), .chip_sel_first_n(chip_sel_first_n),
        .chip_sel_second_n(chip_sel_second_n), .chip_sel_third(chip_sel_third), .clk_en_n(clk_en_n),
        .wr_sel_n(wr_sel_n), .advance_load_sel(advance_load_sel), .data_in(data_in));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic summarize;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk_vec(input logic [35:0] got, input logic [35:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp, input string what);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask
    task automatic tick;
        @(posedge ref_clk);
        #1;
    endtask
    task automatic idle;
        i_ctl.drive(1'b0, 1'b0, 6'h0, 1'b0, 4'h0, 3'h0, 36'h0);
    endtask
    task automatic wr_op(input logic ce, input logic [5:0] a, input logic [3:0] ln, input logic [2:0] sel,
                         input logic [35:0] d);
        tick;
        i_ctl.drive(ce, 1'b0, a, 1'b1, ln, sel, d);
        for (int i = 0; i < 4; i++)
            if (ce && sel == 3'h7 && !snooze_req && ln[i])
                mem_e[a][i*9 +: 9] = d[i*9 +: 9];
        tick;
        idle;
    endtask
    task automatic rd_op(input logic [5:0] a, input logic [2:0] sel, input logic oe);
        tick;
        i_ctl.drive(1'b1, 1'b0, a, 1'b0, 4'h0, sel, 36'h0);
        tick;
        chk_bit(data_oe, oe, "drive enable");
        if (oe)
            chk_vec(data_out, mem_e[a], "read data");
        idle;
    endtask
    // advance beats flip the read/write select and scramble the address
    task automatic burst(input logic [3:0] up, input logic [1:0] base, input logic wr, input logic [35:0] d);
        logic [1:0] lsb;
        for (int k = 0; k < 5; k++) begin
            tick;
            lsb = burst_order_sel ? base ^ 2'(k - 1) : base + 2'(k - 1);
            if (!wr && k > 0)
                chk_vec(data_out, mem_e[{up, lsb}], "burst beat");
            lsb = burst_order_sel ? base ^ 2'(k) : base + 2'(k);
            if (k == 4) begin
                idle;
            end else begin
                i_ctl.drive(1'b1, k > 0, k == 0 ? {up, base} : 6'h3F, k == 0 ? wr : !wr,
                            wr ? 4'hF : 4'h0, 3'h7, d + 36'(k));
                if (wr)
                    mem_e[{up, lsb}] = d + 36'(k);
            end
        end
    endtask
    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        #400000;
        err_total++;
        summarize;
    end
    initial begin
        for (int i = 0; i < 64; i++)
            mem_e[i] = 36'h0;
        repeat (2) @(posedge ref_clk);
        #1;
        reset = 1'b0;
        chk_bit(data_oe, 1'b0, "reset enable");
        chk_vec(data_out, 36'h0, "reset data");
        repeat (2) tick;
        wr_op(1'b1, 6'h05, 4'hF, 3'h7, 36'h9_1234_5678);
        rd_op(6'h05, 3'h7, 1'b1);
        wr_op(1'b1, 6'h05, 4'h5, 3'h7, 36'hF_0F0F_0F0F);
        rd_op(6'h05, 3'h7, 1'b1);
        for (int s = 0; s < 3; s++) begin
            wr_op(1'b1, 6'h05, 4'hF, 3'h7 ^ 3'(1 << s), 36'h0_DEAD_BEEF);
            rd_op(6'h05, 3'h7 ^ 3'(1 << s), 1'b0);
            rd_op(6'h05, 3'h7, 1'b1);
        end
        wr_op(1'b0, 6'h05, 4'hF, 3'h7, 36'h0_1111_2222);
        rd_op(6'h05, 3'h7, 1'b1);
        tick;
        i_ctl.drive(1'b1, 1'b0, 6'h05, 1'b0, 4'h0, 3'h7, 36'h0);
        tick;
        i_ctl.drive(1'b0, 1'b0, 6'h0A, 1'b0, 4'h0, 3'h7, 36'h0);
        tick;
        chk_vec(data_out, mem_e[5], "stalled read");
        idle;
        burst(4'h3, 2'h2, 1'b1, 36'h1_0000_0010);
        burst(4'h3, 2'h2, 1'b0, 36'h0);
        tick;
        burst_order_sel = 1'b1;
        burst(4'h4, 2'h1, 1'b1, 36'h2_0000_0020);
        burst(4'h4, 2'h1, 1'b0, 36'h0);
        snooze_req = 1'b1;
        repeat (3) tick;
        wr_op(1'b1, 6'h05, 4'hF, 3'h7, 36'h0_5555_AAAA);
        rd_op(6'h05, 3'h7, 1'b0);
        snooze_req = 1'b0;
        repeat (3) tick;
        rd_op(6'h05, 3'h7, 1'b1);
        out_en_n = 1'b1;
        repeat (3) tick;
        rd_op(6'h05, 3'h7, 1'b0);
        out_en_n = 1'b0;
        repeat (3) tick;
        rd_op(6'h05, 3'h7, 1'b1);
        summarize;
    end
endmodule
`default_nettype wire
